/* File: src/bpcs_regs.vh */
// Register offsets, field positions and reset values for the bridge command/status bank
`ifndef BPCS_REGS_VH
`define BPCS_REGS_VH
`define BPCS_OFS_CMD 8'h04
`define BPCS_OFS_STS 8'h06
`define BPCS_CMD_RESET 16'h0000
`define BPCS_STS_RESET 16'h0010
`define BPCS_CMD_RW_MASK 16'h0157
`define BPCS_CMD_IO 0
`define BPCS_CMD_MEM 1
`define BPCS_CMD_MASTER 2
`define BPCS_CMD_MWI 4
`define BPCS_CMD_PERR 6
`define BPCS_CMD_SERR 8
`define BPCS_STS_MASTER_POISON 8
`define BPCS_STS_CA_SENT 11
`define BPCS_STS_CA_SEEN 12
`define BPCS_STS_UR_SEEN 13
`define BPCS_STS_ERR_SENT 14
`define BPCS_STS_POISON 15
`define BPCS_STS_CAP_CHAIN 4
`endif

/* File: src/bpcs_sticky.v */
// One write-one-to-clear sticky flag with set priority
`timescale 1ns/100ps
module bpcs_sticky (
  input wire clk,
  input wire rst_n,
  input wire set_i,
  input wire clr_i,
  output reg flag_r
);
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_r <= 1'b0;
    end else if (set_i) begin
      // Set wins so a same-cycle event is not lost
      flag_r <= 1'b1;
    end else if (clr_i) begin
      flag_r <= 1'b0;
    end
  end
endmodule

/* File: src/bpcs_gate.v */
// Request acceptance and promotion decisions steered by command bits
`timescale 1ns/100ps
module bpcs_gate (
  input wire clk,
  input wire rst_n,
  input wire [15:0] cmd,
  input wire dn_mem_req,
  input wire dn_io_req,
  input wire up_req,
  input wire dn_mem_write,
  output reg dn_accept_r,
  output reg dn_unsupported_r,
  output reg up_forward_r,
  output reg mwi_issue_r
);
  `include "bpcs_regs.vh"
  wire mem_ok;
  wire io_ok;
  assign mem_ok = dn_mem_req & cmd[`BPCS_CMD_MEM];
  assign io_ok = dn_io_req & cmd[`BPCS_CMD_IO];
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dn_accept_r <= 1'b0;
      dn_unsupported_r <= 1'b0;
      up_forward_r <= 1'b0;
      mwi_issue_r <= 1'b0;
    end else begin
      dn_accept_r <= mem_ok | io_ok;
      dn_unsupported_r <= (dn_mem_req & ~cmd[`BPCS_CMD_MEM]) | (dn_io_req & ~cmd[`BPCS_CMD_IO]);
      up_forward_r <= up_req & cmd[`BPCS_CMD_MASTER];
      mwi_issue_r <= dn_mem_write & mem_ok & cmd[`BPCS_CMD_MWI];
    end
  end
endmodule

/* File: src/bpcs_top.v */
// Primary-side command and status register bank of a serial-to-parallel bus bridge
// Functional notes
// - Command bit 5 always reads zero; palette snooping absent.
// - Command bit 4 set promotes link memory writes to write-and-invalidate.
// - Special cycles ignored; command bit 3 reads zero.
// - Command bit 2 clear blocks upstream requests.
// - Command bit 1 clear answers downstream memory requests as unsupported.
// - Command bit 0 clear answers downstream I/O requests as unsupported.
// - Status bit 15 sets on any poisoned packet, regardless of bit 6.
// - Status bit 14 sets on sent error message while error enable set.
// - Status bit 13 sets on received unsupported-request completion.
// - Status bit 12 sets on received completer-abort completion.
// - Status bit 11 sets when the device returns completer abort.
// - Status bit 8 sets on poisoned completion/write only with command bit 6.
// - Status bits 10:9 read 00.
// - Status bits 7 and 5 read zero.
// - Status bit 4 reads one.
// - Status bit 3 reads zero.
// - Status bits 6 and 2:0 read zero.
// - Error reports for parallel-bus system errors only while command bit 8 set.
// - Poisoned packets forwarded with bad parity whatever command bit 6.
`timescale 1ns/100ps
module bpcs_top (
  input wire clk,
  input wire rst_n,
  input wire cfg_wr,
  input wire cfg_rd,
  input wire [7:0] cfg_addr,
  input wire [1:0] cfg_be,
  input wire [15:0] cfg_wdata,
  output reg [15:0] cfg_rdata_r,
  output reg cfg_rvalid_r,
  input wire poisoned_packet_seen,
  input wire poisoned_cpl_data,
  input wire poisoned_write_req,
  input wire unsupported_completion_seen,
  input wire completer_abort_seen,
  input wire completer_abort_sent,
  input wire error_message_sent,
  input wire pbus_serr_seen,
  input wire dn_mem_req,
  input wire dn_io_req,
  input wire dn_mem_write,
  input wire up_req,
  output reg err_msg_req_r,
  output reg bad_parity_fwd_r,
  output wire dn_accept_r,
  output wire dn_unsupported_r,
  output wire up_forward_r,
  output wire mwi_issue_r,
  output reg [15:0] cmd_out_r
);
  `include "bpcs_regs.vh"
  reg [15:0] cmd_r;
  reg [15:0] cmd_nxt;
  wire [15:0] sts_val;
  wire [5:0] sticky_set;
  wire [5:0] sticky_clr;
  wire [5:0] sticky_q;
  wire wr_cmd;
  wire wr_sts;

  // Byte-enable write merge for read/write bits only
  function [15:0] be_merge;
    input [15:0] old_v;
    input [15:0] new_v;
    input [1:0] be;
    begin
      be_merge = old_v;
      if (be[0]) be_merge[7:0] = new_v[7:0];
      if (be[1]) be_merge[15:8] = new_v[15:8];
      be_merge = be_merge & `BPCS_CMD_RW_MASK;
    end
  endfunction

  assign wr_cmd = cfg_wr & (cfg_addr == `BPCS_OFS_CMD);
  assign wr_sts = cfg_wr & (cfg_addr == `BPCS_OFS_STS);

  always @* begin
    cmd_nxt = cmd_r;
    if (wr_cmd) begin
      cmd_nxt = be_merge(cmd_r, cfg_wdata, cfg_be);
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cmd_r <= `BPCS_CMD_RESET;
      cmd_out_r <= `BPCS_CMD_RESET;
    end else begin
      cmd_r <= cmd_nxt;
      cmd_out_r <= cmd_nxt;
    end
  end

  // Flag order: 8, 11, 12, 13, 14, 15
  assign sticky_set[0] = cmd_r[`BPCS_CMD_PERR] & (poisoned_cpl_data | poisoned_write_req);
  assign sticky_set[1] = completer_abort_sent;
  assign sticky_set[2] = completer_abort_seen;
  assign sticky_set[3] = unsupported_completion_seen;
  assign sticky_set[4] = error_message_sent & cmd_r[`BPCS_CMD_SERR];
  assign sticky_set[5] = poisoned_packet_seen;
  // Write-one clears; upper byte lane holds every flag
  assign sticky_clr = (wr_sts & cfg_be[1]) ?
    {cfg_wdata[15:11], cfg_wdata[8]} : 6'h00;

  genvar gi;
  generate
    for (gi = 0; gi < 6; gi = gi + 1) begin : g_flag
      bpcs_sticky u_flag (
        .clk(clk),
        .rst_n(rst_n),
        .set_i(sticky_set[gi]),
        .clr_i(sticky_clr[gi]),
        .flag_r(sticky_q[gi])
      );
    end
  endgenerate

  // Hardwired bits fixed at zero, capability chain at one
  assign sts_val = {sticky_q[5:1], 2'b00, sticky_q[0], 8'h10};

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_rdata_r <= 16'h0000;
      cfg_rvalid_r <= 1'b0;
      err_msg_req_r <= 1'b0;
      bad_parity_fwd_r <= 1'b0;
    end else begin
      cfg_rvalid_r <= cfg_rd;
      if (cfg_rd) begin
        case (cfg_addr)
          `BPCS_OFS_CMD: cfg_rdata_r <= cmd_r;
          `BPCS_OFS_STS: cfg_rdata_r <= sts_val;
          default: cfg_rdata_r <= 16'h0000;
        endcase
      end
      err_msg_req_r <= pbus_serr_seen & cmd_r[`BPCS_CMD_SERR];
      bad_parity_fwd_r <= poisoned_packet_seen;
    end
  end

  bpcs_gate u_gate (
    .clk(clk),
    .rst_n(rst_n),
    .cmd(cmd_r),
    .dn_mem_req(dn_mem_req),
    .dn_io_req(dn_io_req),
    .up_req(up_req),
    .dn_mem_write(dn_mem_write),
    .dn_accept_r(dn_accept_r),
    .dn_unsupported_r(dn_unsupported_r),
    .up_forward_r(up_forward_r),
    .mwi_issue_r(mwi_issue_r)
  );
endmodule

/* File: verification/bpcs_assertions.sv */
// Port-level checks of the bridge command/status bank
`timescale 1ns/100ps
module bpcs_assertions (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic dn_mem_req,
  input wire logic dn_io_req,
  input wire logic dn_mem_write,
  input wire logic poisoned_packet_seen,
  input wire logic pbus_serr_seen,
  input wire logic err_msg_req_r,
  input wire logic bad_parity_fwd_r,
  input wire logic dn_accept_r,
  input wire logic dn_unsupported_r,
  input wire logic up_forward_r,
  input wire logic mwi_issue_r,
  input wire logic [15:0] cmd_out_r
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_cmd_ro_zero: assert property ((cmd_out_r & 16'hfea8) == 16'h0000)
    else $error("command read-only bit set");
  a_mem_unsup: assert property (dn_mem_req && !cmd_out_r[1] |=> dn_unsupported_r)
    else $error("memory request not refused");
  a_io_unsup: assert property (dn_io_req && !cmd_out_r[0] |=> dn_unsupported_r)
    else $error("io request not refused");
  a_mem_accept: assert property (dn_mem_req && cmd_out_r[1] |=> dn_accept_r)
    else $error("memory request not accepted");
  a_up_blocked: assert property (!cmd_out_r[2] |=> !up_forward_r)
    else $error("upstream forward while disabled");
  a_mwi_follows: assert property (dn_mem_req && dn_mem_write && cmd_out_r[1] |=> mwi_issue_r == $past(cmd_out_r[4]))
    else $error("write promotion wrong");
  a_serr_gate: assert property (pbus_serr_seen |=> err_msg_req_r == $past(cmd_out_r[8]))
    else $error("error report gating wrong");
  a_poison_fwd: assert property (poisoned_packet_seen |=> bad_parity_fwd_r)
    else $error("poison not forwarded");
endmodule
bind bpcs_top bpcs_assertions bpcs_assertions_i (.*);

/* File: verification/bpcs_link_model.sv */
// Upstream link model: replays requested events as one-cycle pulses
`timescale 1ns/100ps
module bpcs_link_model (
  input wire logic clk,
  input wire logic [7:0] ev_req,
  output wire logic poisoned_packet_seen,
  output wire logic poisoned_cpl_data,
  output wire logic poisoned_write_req,
  output wire logic unsupported_completion_seen,
  output wire logic completer_abort_seen,
  output wire logic completer_abort_sent,
  output wire logic error_message_sent,
  output wire logic pbus_serr_seen
);
  // Registered so pulses leave on a clean edge, never mid-cycle
  logic [7:0] ev_r = 8'h00;
  always @(posedge clk) ev_r <= ev_req;
  assign {pbus_serr_seen, error_message_sent, completer_abort_sent, completer_abort_seen} = ev_r[7:4];
  assign {unsupported_completion_seen, poisoned_write_req, poisoned_cpl_data, poisoned_packet_seen} = ev_r[3:0];
endmodule

/* File: verification/tb.sv */
// Self-checking bench for the bridge command/status bank
`timescale 1ns/100ps
module tb;
  logic clk = '0, rst_n = '0, cfg_wr = '0, cfg_rd = '0, dn_mem_req = '0, dn_io_req = '0, dn_mem_write = '0;
  logic up_req = '0, cfg_rvalid_r, err_msg_req_r, bad_parity_fwd_r, dn_accept_r, dn_unsupported_r, up_forward_r;
  logic mwi_issue_r, poisoned_packet_seen, poisoned_cpl_data, poisoned_write_req, unsupported_completion_seen;
  logic completer_abort_seen, completer_abort_sent, error_message_sent, pbus_serr_seen;
  logic [7:0] cfg_addr = '0, ev_req = '0;
  logic [1:0] cfg_be = '0;
  logic [7:0] e8;
  logic [15:0] cfg_wdata = '0, cfg_rdata_r, cmd_out_r, c, s;
  int fails = 0, checks_done = 0;
  bpcs_top bpcs_top_i (.*);
  bpcs_link_model bpcs_link_model_i (.*);
  initial forever #20 clk = ~clk;
  initial begin
    #2000000;
    fails++;
    final_report;
  end
  task automatic chk(string n, logic [15:0] e, logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      fails++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [15:0] d, logic [1:0] b);
    @(posedge clk) #1;
    {cfg_wr, cfg_addr, cfg_wdata, cfg_be} = {1'h1, a, d, b};
    @(posedge clk) #1 cfg_wr = '0;
  endtask
  // Read data answers one cycle after the request edge
  task automatic rd(logic [7:0] a, logic [15:0] e, string n);
    @(posedge clk) #1;
    {cfg_rd, cfg_addr} = {1'h1, a};
    @(posedge clk) #1 cfg_rd = '0;
    chk("rvalid", 16'h0001, {15'h0000, cfg_rvalid_r});
    chk(n, e, cfg_rdata_r);
  endtask
  function automatic logic [15:0] exp_sts(logic [7:0] e, logic [15:0] k);
    return {e[0], e[6] & k[8], e[3], e[4], e[5], 2'h0, (e[1] | e[2]) & k[6], 8'h10};
  endfunction
  task final_report;
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    void'($urandom(50494));
    repeat (8) @(posedge clk);
    #1 rst_n = '1;
    rd(8'h04, 16'h0000, "cmd");
    rd(8'h06, 16'h0010, "sts");
    rd(8'h08, 16'h0000, "unmapped");
    for (int i = 0; i < 40; i++) begin
      // First two passes pin all-zero and all-one commands
      c = (i < 2) ? {16{i[0]}} : 16'($urandom);
      wr(8'h04, c, 2'h3);
      rd(8'h04, c & 16'h0157, "cmd");
      @(posedge clk) #1;
      {dn_mem_req, dn_io_req, dn_mem_write, up_req, ev_req} = 12'($urandom);
      s = exp_sts(ev_req, c);
      @(posedge clk) #1;
      chk("unsup", {15'h0000, (dn_mem_req & ~c[1]) | (dn_io_req & ~c[0])}, {15'h0000, dn_unsupported_r});
      chk("accept", {15'h0000, (dn_mem_req & c[1]) | (dn_io_req & c[0])}, {15'h0000, dn_accept_r});
      chk("upfwd", {15'h0000, up_req & c[2]}, {15'h0000, up_forward_r});
      chk("promote", {15'h0000, dn_mem_write & dn_mem_req & c[1] & c[4]}, {15'h0000, mwi_issue_r});
      chk("cmdout", c & 16'h0157, cmd_out_r);
      e8 = ev_req;
      {dn_mem_req, dn_io_req, dn_mem_write, up_req, ev_req} = 12'h000;
      // Link model delays events one cycle, so their effects show one cycle later
      @(posedge clk) #1;
      chk("errmsg", {15'h0000, e8[7] & c[8]}, {15'h0000, err_msg_req_r});
      chk("badpar", {15'h0000, e8[0]}, {15'h0000, bad_parity_fwd_r});
      wr(8'h06, 16'h0000, 2'h3);
      rd(8'h06, s, "sts");
      wr(8'h06, 16'hffff, 2'h2);
      rd(8'h06, 16'h0010, "sts clear");
    end
    final_report;
  end
endmodule
